// file: hw/rsc_defines.vh
// Constants of the reset source controller: register map, fields, reset values, timing
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH

// ----------------------------------------------------------------
// Register indices and byte addresses (byte address = 4 * index)
// ----------------------------------------------------------------
`define RSC_IDX_POWER_CONTROL        8'h87
`define RSC_IDX_RSR         8'h96
`define RSC_IDX_CHIP_CONTROL      8'h9f
`define RSC_IDX_WATCHDOG_CONTROL       8'haa
`define RSC_IDX_PMC         8'hac
`define RSC_ADDR_POWER_CONTROL       {22'h000000, `RSC_IDX_POWER_CONTROL, 2'b00}
`define RSC_ADDR_RSR        {22'h000000, `RSC_IDX_RSR, 2'b00}
`define RSC_ADDR_CHIP_CONTROL     {22'h000000, `RSC_IDX_CHIP_CONTROL, 2'b00}
`define RSC_ADDR_WATCHDOG_CONTROL      {22'h000000, `RSC_IDX_WATCHDOG_CONTROL, 2'b00}
`define RSC_ADDR_PMC        {22'h000000, `RSC_IDX_PMC, 2'b00}

// ----------------------------------------------------------------
// Decoded register select codes
// ----------------------------------------------------------------
`define RSC_SEL_NONE        3'h0
`define RSC_SEL_POWER_CONTROL        3'h1
`define RSC_SEL_RSR         3'h2
`define RSC_SEL_CHIP_CONTROL      3'h3
`define RSC_SEL_WATCHDOG_CONTROL       3'h4
`define RSC_SEL_PMC         3'h5

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RSC_POWER_CONTROL_COLD_BIT   4
`define RSC_POWER_CONTROL_PD_BIT     1
`define RSC_POWER_CONTROL_IDLE_BIT   0
`define RSC_POWER_CONTROL_RW_MASK    8'h8f
`define RSC_RSR_BROWN_BIT   2
`define RSC_RSR_SOFT_BIT    0
`define RSC_WATCHDOG_CONTROL_EN_BIT    7
`define RSC_WATCHDOG_CONTROL_CLR_BIT   6
`define RSC_WATCHDOG_CONTROL_PD_BIT    4
`define RSC_WATCHDOG_CONTROL_FLAG_BIT  3
`define RSC_WATCHDOG_CONTROL_RW_MASK   8'h97
`define RSC_PMC_DETECT_BIT  7
`define RSC_PMC_BROWNOUT_RESET_ENABLE_BIT   4
`define RSC_PMC_STATUS_BIT  0
`define RSC_CHP_SWREQ_BIT   7
`define RSC_CHP_RW_MASK     8'h73

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RSC_POWER_CONTROL_RESET      8'h00
`define RSC_WATCHDOG_CONTROL_RESET     8'h00
`define RSC_CHIP_CONTROL_RESET    8'h00
`define RSC_BOOT_VECTOR     16'h0000

// ----------------------------------------------------------------
// Timing in clocks (one machine cycle = 12 clocks)
// ----------------------------------------------------------------
`define RSC_CLKS_PER_MC     12
`define RSC_HOLD_MC         2
`define RSC_HOLD_CLKS       (`RSC_HOLD_MC * `RSC_CLKS_PER_MC)
`define RSC_PIN_EXIT_CLKS   (`RSC_CLKS_PER_MC)
`define RSC_PIN_DETECT_CLKS (`RSC_HOLD_MC * `RSC_CLKS_PER_MC)
`define RSC_CNT_W           6

`endif

// file: hw/rsc_hold_counter.v
// Loadable down counter that times a reset hold
`timescale 1ns/10ps
`default_nettype none
`include "rsc_defines.vh"

module rsc_hold_counter (
    // Clock and reset
    input  wire                 clk,
    input  wire                 nrst,
    // Control
    input  wire                 load,
    input  wire [`RSC_CNT_W-1:0] load_val,
    // Status
    output wire                 done
);

    // Full hold length at counter width
    localparam [`RSC_CNT_W-1:0] HOLD_INIT = `RSC_HOLD_CLKS;

    reg [`RSC_CNT_W-1:0] cnt_reg;

    // Power-on starts a full hold; otherwise count down to zero
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= HOLD_INIT;
        end else if (load) begin
            cnt_reg <= load_val;
        end else if (cnt_reg != {`RSC_CNT_W{1'b0}}) begin
            cnt_reg <= cnt_reg - {{(`RSC_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    assign done = (cnt_reg == {`RSC_CNT_W{1'b0}});

endmodule

`default_nettype wire

// file: hw/rsc_sync.v
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/10ps
`default_nettype none

module rsc_sync #(
    parameter W = 2
) (
    // Clock and reset
    input  wire         clk,
    input  wire         nrst,
    // Levels
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);

    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    // First stage feeds only the second
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule

`default_nettype wire

// file: hw/rsc_top.v
// Reset source controller with cause flags and AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "rsc_defines.vh"

module rsc_top (
    // Clock and power-on reset
    input  wire        CLK,
    input  wire        NRST,
    // AHB-Lite slave
    input  wire        HSEL,
    input  wire [31:0] HADDR,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire [31:0] HWDATA,
    input  wire        HREADY,
    output wire        HREADYOUT,
    output wire        HRESP,
    output wire [31:0] HRDATA,
    // Reset sources
    input  wire        RST_PIN,
    input  wire        WDT_TIMEOUT,
    input  wire        BOD_LOW,
    input  wire        CFG_BOR_ENABLE,
    // CPU side
    output wire        CPU_RESET,
    output wire [15:0] BOOT_VECTOR,
    output wire        CPU_IDLE,
    output wire        CPU_POWER_DOWN,
    output wire        CLK_STOP,
    // Watchdog and brown-out control
    output wire        WDT_ENABLE,
    output wire        WDT_RUN_IN_PD,
    output wire [2:0]  WDT_SELECT,
    output wire        WDT_CLEAR,
    output wire        BOD_ENABLE
);

    // ------------------------------------------------------------
    // States of the reset sequencer
    // ------------------------------------------------------------
    localparam [2:0] ST_RUN   = 3'b001;
    localparam [2:0] ST_LEVEL = 3'b010;
    localparam [2:0] ST_HOLD  = 3'b100;

    localparam [`RSC_CNT_W-1:0] HOLD_CLKS   = `RSC_HOLD_CLKS;
    localparam [`RSC_CNT_W-1:0] PIN_EXIT    = `RSC_PIN_EXIT_CLKS;
    localparam [`RSC_CNT_W-1:0] PIN_DETECT  = `RSC_PIN_DETECT_CLKS;

    // Register select decode, shared by read and write paths
    function [2:0] rsc_decode;
        input [31:0] addr;
        begin
            case (addr)
                `RSC_ADDR_POWER_CONTROL:   rsc_decode = `RSC_SEL_POWER_CONTROL;
                `RSC_ADDR_RSR:    rsc_decode = `RSC_SEL_RSR;
                `RSC_ADDR_CHIP_CONTROL: rsc_decode = `RSC_SEL_CHIP_CONTROL;
                `RSC_ADDR_WATCHDOG_CONTROL:  rsc_decode = `RSC_SEL_WATCHDOG_CONTROL;
                `RSC_ADDR_PMC:    rsc_decode = `RSC_SEL_PMC;
                default:          rsc_decode = `RSC_SEL_NONE;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    wire [1:0]            sync_lvl;
    wire                  pin_sync;
    wire                  bod_sync;
    wire                  hold_done;
    reg                   hold_load;
    reg  [`RSC_CNT_W-1:0] hold_val;
    reg  [2:0]            state_reg;
    reg  [2:0]            state_next;
    reg  [`RSC_CNT_W-1:0] pin_cnt_reg;
    wire                  pin_valid;
    wire                  bod_trip;
    wire                  sfr_rst;
    reg                   set_brown;
    reg                   set_soft;
    reg                   set_wdt;
    reg                   level_is_pin_reg;
    reg                   cpu_reset_reg;
    reg                   soft_req_reg;
    reg                   wdt_clear_reg;
    reg  [7:0]            power_control_reg;
    reg  [7:0]            watchdog_control_reg;
    reg  [7:0]            chip_control_reg;
    reg                   bod_en_reg;
    reg                   brownout_reset_enable_reg;
    reg                   cold_start_flag_reg;
    reg                   brownout_cause_flag_reg;
    reg                   soft_cause_flag_reg;
    reg                   watchdog_cause_flag_reg;
    reg                   wr_pend_reg;
    reg                   rd_wait_reg;
    reg  [2:0]            sel_reg;
    reg  [31:0]           hrdata_reg;
    reg  [7:0]            rd_byte;
    wire                  addr_phase;
    wire                  wr_go;
    wire [7:0]            wdata;

    // ------------------------------------------------------------
    // Input synchronisers and hold timer
    // ------------------------------------------------------------
    // Pin and comparator are asynchronous levels
    rsc_sync #(
        .W(2)
    ) u_sync (
        .clk      (CLK),
        .nrst     (NRST),
        .async_in ({BOD_LOW, RST_PIN}),
        .sync_out (sync_lvl)
    );

    assign pin_sync = sync_lvl[0];
    assign bod_sync = sync_lvl[1];

    rsc_hold_counter u_hold (
        .clk      (CLK),
        .nrst     (NRST),
        .load     (hold_load),
        .load_val (hold_val),
        .done     (hold_done)
    );

    // ------------------------------------------------------------
    // Pin qualification
    // ------------------------------------------------------------
    // Pin must stay high two machine cycles to count as a reset
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pin_cnt_reg <= {`RSC_CNT_W{1'b0}};
        end else if (!pin_sync) begin
            pin_cnt_reg <= {`RSC_CNT_W{1'b0}};
        end else if (pin_cnt_reg != PIN_DETECT) begin
            pin_cnt_reg <= pin_cnt_reg + {{(`RSC_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    assign pin_valid = (pin_cnt_reg == PIN_DETECT);
    assign bod_trip  = bod_sync & brownout_reset_enable_reg;

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    // Next state, hold loads and cause events
    always @* begin
        state_next = state_reg;
        hold_load  = 1'b0;
        hold_val   = HOLD_CLKS;
        set_brown  = 1'b0;
        set_soft   = 1'b0;
        set_wdt    = 1'b0;
        case (state_reg)
            ST_RUN: begin
                if (pin_valid || bod_trip) begin
                    state_next = ST_LEVEL;
                    set_brown  = bod_trip & ~pin_valid;
                end else if (WDT_TIMEOUT) begin
                    state_next = ST_HOLD;
                    hold_load  = 1'b1;
                    set_wdt    = 1'b1;
                end else if (soft_req_reg) begin
                    state_next = ST_HOLD;
                    hold_load  = 1'b1;
                    set_soft   = 1'b1;
                end
            end
            ST_LEVEL: begin
                // Stay while pin is high or supply stays low
                if (!(pin_sync || bod_trip)) begin
                    state_next = ST_HOLD;
                    hold_load  = 1'b1;
                    hold_val   = level_is_pin_reg ? PIN_EXIT : HOLD_CLKS;
                end
            end
            ST_HOLD: begin
                if (pin_valid || bod_trip) begin
                    state_next = ST_LEVEL;
                    set_brown  = bod_trip & ~pin_valid;
                end else if (hold_done) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_HOLD;
                hold_load  = 1'b1;
            end
        endcase
    end

    // State, level source and registered CPU reset
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_reg        <= ST_HOLD;
            level_is_pin_reg <= 1'b0;
            cpu_reset_reg    <= 1'b1;
        end else begin
            state_reg     <= state_next;
            cpu_reset_reg <= (state_next != ST_RUN);
            if (state_reg != ST_LEVEL && state_next == ST_LEVEL) begin
                level_is_pin_reg <= pin_valid;
            end
        end
    end

    // Control registers below return to reset values while the CPU is held, the brown-out enables to CFG_BOR_ENABLE; cause flags keep theirs
    assign sfr_rst = (state_reg != ST_RUN);

    // ------------------------------------------------------------
    // AHB-Lite slave front end
    // ------------------------------------------------------------
    assign addr_phase = HSEL & HREADY & HTRANS[1];
    assign wdata      = HWDATA[7:0];
    assign wr_go      = wr_pend_reg & ~sfr_rst;

    // Address phase capture; reads take one wait state
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            wr_pend_reg <= 1'b0;
            rd_wait_reg <= 1'b0;
            sel_reg     <= `RSC_SEL_NONE;
        end else begin
            wr_pend_reg <= addr_phase & HWRITE;
            rd_wait_reg <= addr_phase & ~HWRITE;
            if (addr_phase) begin
                sel_reg <= rsc_decode(HADDR);
            end
        end
    end

    // Read mux of the selected register
    always @* begin
        case (sel_reg)
            `RSC_SEL_POWER_CONTROL: begin
                rd_byte = power_control_reg & `RSC_POWER_CONTROL_RW_MASK;
                rd_byte[`RSC_POWER_CONTROL_COLD_BIT] = cold_start_flag_reg;
            end
            `RSC_SEL_RSR: begin
                rd_byte = 8'h00;
                rd_byte[`RSC_RSR_BROWN_BIT] = brownout_cause_flag_reg;
                rd_byte[`RSC_RSR_SOFT_BIT]  = soft_cause_flag_reg;
            end
            `RSC_SEL_CHIP_CONTROL: begin
                rd_byte = chip_control_reg & `RSC_CHP_RW_MASK;
                rd_byte[`RSC_CHP_SWREQ_BIT] = soft_req_reg;
            end
            `RSC_SEL_WATCHDOG_CONTROL: begin
                rd_byte = watchdog_control_reg & `RSC_WATCHDOG_CONTROL_RW_MASK;
                rd_byte[`RSC_WATCHDOG_CONTROL_FLAG_BIT] = watchdog_cause_flag_reg;
            end
            `RSC_SEL_PMC: begin
                rd_byte = 8'h00;
                rd_byte[`RSC_PMC_DETECT_BIT] = bod_en_reg;
                rd_byte[`RSC_PMC_BROWNOUT_RESET_ENABLE_BIT]  = brownout_reset_enable_reg;
                rd_byte[`RSC_PMC_STATUS_BIT] = bod_sync & bod_en_reg;
            end
            default: rd_byte = 8'h00;
        endcase
    end

    // Read data register, loaded in the wait cycle
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            hrdata_reg <= 32'h00000000;
        end else if (rd_wait_reg) begin
            hrdata_reg <= {24'h000000, rd_byte};
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Plain control bits, cleared on every reset source; the brown-out enables load CFG_BOR_ENABLE
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            power_control_reg      <= `RSC_POWER_CONTROL_RESET;
            watchdog_control_reg     <= `RSC_WATCHDOG_CONTROL_RESET;
            chip_control_reg    <= `RSC_CHIP_CONTROL_RESET;
            bod_en_reg    <= 1'b0;
            brownout_reset_enable_reg     <= 1'b0;
            soft_req_reg  <= 1'b0;
            wdt_clear_reg <= 1'b0;
        end else if (sfr_rst) begin
            power_control_reg      <= `RSC_POWER_CONTROL_RESET;
            watchdog_control_reg     <= `RSC_WATCHDOG_CONTROL_RESET;
            chip_control_reg    <= `RSC_CHIP_CONTROL_RESET;
            bod_en_reg    <= CFG_BOR_ENABLE;
            brownout_reset_enable_reg     <= CFG_BOR_ENABLE;
            soft_req_reg  <= 1'b0;
            wdt_clear_reg <= 1'b0;
        end else begin
            wdt_clear_reg <= wr_go && sel_reg == `RSC_SEL_WATCHDOG_CONTROL && wdata[`RSC_WATCHDOG_CONTROL_CLR_BIT];
            if (wr_go && sel_reg == `RSC_SEL_POWER_CONTROL) begin
                power_control_reg <= wdata & `RSC_POWER_CONTROL_RW_MASK;
            end
            if (wr_go && sel_reg == `RSC_SEL_WATCHDOG_CONTROL) begin
                watchdog_control_reg <= wdata & `RSC_WATCHDOG_CONTROL_RW_MASK;
            end
            if (wr_go && sel_reg == `RSC_SEL_CHIP_CONTROL) begin
                chip_control_reg <= wdata & `RSC_CHP_RW_MASK;
                if (wdata[`RSC_CHP_SWREQ_BIT]) begin
                    soft_req_reg <= 1'b1;
                end
            end
            if (wr_go && sel_reg == `RSC_SEL_PMC) begin
                bod_en_reg <= wdata[`RSC_PMC_DETECT_BIT];
                brownout_reset_enable_reg  <= wdata[`RSC_PMC_BROWNOUT_RESET_ENABLE_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Reset cause flags
    // ------------------------------------------------------------
    // Power-on sets cold start and clears the rest; set beats clear
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cold_start_flag_reg     <= 1'b1;
            brownout_cause_flag_reg <= 1'b0;
            soft_cause_flag_reg     <= 1'b0;
            watchdog_cause_flag_reg <= 1'b0;
        end else begin
            if (wr_go && sel_reg == `RSC_SEL_POWER_CONTROL) begin
                cold_start_flag_reg <= wdata[`RSC_POWER_CONTROL_COLD_BIT];
            end
            if (set_brown) begin
                brownout_cause_flag_reg <= 1'b1;
            end else if (wr_go && sel_reg == `RSC_SEL_RSR) begin
                brownout_cause_flag_reg <= wdata[`RSC_RSR_BROWN_BIT];
            end
            if (set_soft) begin
                soft_cause_flag_reg <= 1'b1;
            end else if (wr_go && sel_reg == `RSC_SEL_RSR) begin
                soft_cause_flag_reg <= wdata[`RSC_RSR_SOFT_BIT];
            end
            if (set_wdt) begin
                watchdog_cause_flag_reg <= 1'b1;
            end else if (wr_go && sel_reg == `RSC_SEL_WATCHDOG_CONTROL) begin
                watchdog_cause_flag_reg <= wdata[`RSC_WATCHDOG_CONTROL_FLAG_BIT];
            end
        end
    end
    // A pin reset touches none of the flags above

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Bus answers: write zero wait, read one wait, always OKAY
    assign HREADYOUT = ~rd_wait_reg;
    assign HRESP     = 1'b0;
    assign HRDATA    = hrdata_reg;

    // CPU reset and fixed restart address
    assign CPU_RESET   = cpu_reset_reg;
    assign BOOT_VECTOR = `RSC_BOOT_VECTOR;

    // Power modes; the pin reopens a stopped clock without it
    assign CPU_IDLE       = power_control_reg[`RSC_POWER_CONTROL_IDLE_BIT];
    assign CPU_POWER_DOWN = power_control_reg[`RSC_POWER_CONTROL_PD_BIT];
    assign CLK_STOP       = power_control_reg[`RSC_POWER_CONTROL_PD_BIT] & ~RST_PIN;

    // Watchdog and brown-out controls
    assign WDT_ENABLE    = watchdog_control_reg[`RSC_WATCHDOG_CONTROL_EN_BIT];
    assign WDT_RUN_IN_PD = watchdog_control_reg[`RSC_WATCHDOG_CONTROL_PD_BIT];
    assign WDT_SELECT    = watchdog_control_reg[2:0];
    assign WDT_CLEAR     = wdt_clear_reg;
    assign BOD_ENABLE    = bod_en_reg;

endmodule

`default_nettype wire

// file: verif/rsc_src_model.sv
// Model of the reset sources outside the controller
`timescale 1ns/10ps
`default_nettype none
module rsc_src_model (
    // Clock
    input  wire logic clk,
    // Sources
    output var logic  rst_pin,
    output var logic  wdt_timeout,
    output var logic  bod_low
);
    initial {rst_pin, wdt_timeout, bod_low} = 3'h0;
    // Pin high two machine cycles plus sync
    task automatic pin_pulse(input int n);
        @(posedge clk) rst_pin <= 1'b1;
        repeat (n < 26 ? 26 : n) @(posedge clk);
        rst_pin <= 1'b0;
    endtask
    // One-cycle time-out pulse
    task automatic wdt_fire();
        @(posedge clk) wdt_timeout <= 1'b1;
        @(posedge clk) wdt_timeout <= 1'b0;
    endtask
    // Comparator level
    task automatic bod(input logic lvl);
        @(posedge clk) bod_low <= lvl;
    endtask
endmodule
`default_nettype wire

// file: verif/rsc_top_props.sv
// Checker of reset sequencing at the controller ports
`timescale 1ns/10ps
`default_nettype none
module rsc_top_props (
    // Clock, reset, sources
    input wire logic        CLK,
    input wire logic        NRST,
    input wire logic        RST_PIN,
    input wire logic        WDT_TIMEOUT,
    input wire logic        BOD_LOW,
    // CPU side
    input wire logic        CPU_RESET,
    input wire logic [15:0] BOOT_VECTOR,
    input wire logic        CPU_IDLE,
    input wire logic        CPU_POWER_DOWN,
    input wire logic        CLK_STOP,
    input wire logic        WDT_ENABLE,
    input wire logic        WDT_RUN_IN_PD,
    input wire logic [2:0]  WDT_SELECT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    logic [5:0] hi_cnt_reg;
    logic [5:0] pin_cnt_reg;
    // Saturating run lengths of reset and pin high
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            hi_cnt_reg  <= 6'h00;
            pin_cnt_reg <= 6'h00;
        end else begin
            hi_cnt_reg  <= CPU_RESET ? hi_cnt_reg + {5'h00, hi_cnt_reg != 6'h3f} : 6'h00;
            pin_cnt_reg <= RST_PIN ? pin_cnt_reg + {5'h00, pin_cnt_reg != 6'h3f} : 6'h00;
        end
    end
    boot_vec_a: assert property (BOOT_VECTOR == 16'h0000) else $error("boot vector");
    wdt_entry_a: assert property (WDT_TIMEOUT && !CPU_RESET |=> CPU_RESET) else $error("wdt entry");
    hold_len_a: assert property ($fell(CPU_RESET) |-> hi_cnt_reg >= 6'd24) else $error("hold short");
    wdt_exit_a: assert property (disable iff (!NRST || RST_PIN || BOD_LOW)
        WDT_TIMEOUT && !CPU_RESET |-> ##[24:26] !CPU_RESET) else $error("wdt exit");
    pin_in_a: assert property (pin_cnt_reg >= 6'd30 |-> CPU_RESET) else $error("pin hold");
    pin_exit_a: assert property (disable iff (!NRST || BOD_LOW)
        $fell(RST_PIN) && CPU_RESET |-> ##[1:24] (!CPU_RESET || RST_PIN)) else $error("pin exit");
    ctl_clear_a: assert property ($rose(CPU_RESET) |-> ##2 !CPU_IDLE && !CPU_POWER_DOWN
        && !WDT_ENABLE && !WDT_RUN_IN_PD && WDT_SELECT == 3'h0) else $error("controls kept");
    clk_stop_a: assert property (RST_PIN |-> !CLK_STOP) else $error("clock stopped");
    wdt_c: cover property (WDT_TIMEOUT && !CPU_RESET);
    pin_c: cover property (pin_cnt_reg >= 6'd30);
    exit_c: cover property ($fell(CPU_RESET));
endmodule
bind rsc_top rsc_top_props u_props (.CLK(CLK), .NRST(NRST), .RST_PIN(RST_PIN), .WDT_TIMEOUT(WDT_TIMEOUT),
    .BOD_LOW(BOD_LOW), .CPU_RESET(CPU_RESET), .BOOT_VECTOR(BOOT_VECTOR), .CPU_IDLE(CPU_IDLE),
    .CPU_POWER_DOWN(CPU_POWER_DOWN), .CLK_STOP(CLK_STOP), .WDT_ENABLE(WDT_ENABLE),
    .WDT_RUN_IN_PD(WDT_RUN_IN_PD), .WDT_SELECT(WDT_SELECT));
`default_nettype wire

// file: verif/rsc_top_tb_top.sv
// Self-checking bench of the reset source controller
`timescale 1ns/10ps
`default_nettype none
`include "rsc_defines.vh"
module rsc_top_tb_top;
    logic        CLK, NRST, HSEL, HWRITE, CFG_BOR_ENABLE;
    logic [31:0] HADDR, HWDATA;
    logic [1:0]  HTRANS;
    logic [2:0]  HSIZE;
    logic [15:0] seed;
    logic [7:0]  v;
    wire         HREADYOUT, HRESP, CPU_RESET, CPU_IDLE, CPU_POWER_DOWN, CLK_STOP, WDT_ENABLE;
    wire         WDT_RUN_IN_PD, WDT_CLEAR, BOD_ENABLE, RST_PIN, WDT_TIMEOUT, BOD_LOW;
    wire [31:0]  HRDATA;
    wire [15:0]  BOOT_VECTOR;
    wire [2:0]   WDT_SELECT;
    int          fail_count, samples_checked, cycles;
    // Far side and device
    rsc_src_model src (.clk(CLK), .rst_pin(RST_PIN), .wdt_timeout(WDT_TIMEOUT), .bod_low(BOD_LOW));
    rsc_top uut (.CLK(CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
        .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .HRDATA(HRDATA), .RST_PIN(RST_PIN), .WDT_TIMEOUT(WDT_TIMEOUT), .BOD_LOW(BOD_LOW),
        .CFG_BOR_ENABLE(CFG_BOR_ENABLE), .CPU_RESET(CPU_RESET), .BOOT_VECTOR(BOOT_VECTOR),
        .CPU_IDLE(CPU_IDLE), .CPU_POWER_DOWN(CPU_POWER_DOWN), .CLK_STOP(CLK_STOP), .WDT_ENABLE(WDT_ENABLE),
        .WDT_RUN_IN_PD(WDT_RUN_IN_PD), .WDT_SELECT(WDT_SELECT), .WDT_CLEAR(WDT_CLEAR), .BOD_ENABLE(BOD_ENABLE));
    // Clock
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    // Hang limit
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fail_count++;
            complete_run();
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Status flags after the k-th source of the loop
    function automatic logic [7:0] rsr_exp(input int k);
        return (k >= 1) ? 8'h01 : 8'h00;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Single word transfer
    task automatic xfer(input logic [31:0] a, input logic wr, input logic [7:0] d);
        @(posedge CLK);
        {HSEL, HADDR, HTRANS, HWRITE} <= {1'b1, a, 2'b10, wr};
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        {HTRANS, HWDATA} <= {2'b00, 24'h000000, d};
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [7:0] e);
        xfer(a, 1'b0, 8'h00);
        chk(HRDATA, {24'h000000, e});
        chk(HRESP, 1'b0);
    endtask
    task automatic wait_run();
        do @(posedge CLK); while (CPU_RESET !== 1'b0);
    endtask
    task automatic wait_rst();
        do @(posedge CLK); while (CPU_RESET !== 1'b1);
        wait_run();
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        {NRST, HSEL, HADDR, HTRANS, HWRITE, HWDATA} = '0;
        {HSIZE, CFG_BOR_ENABLE, seed} = {3'h2, 1'b1, 16'd48951};
        fail_count = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (8) @(posedge CLK);
        NRST <= 1'b1;
        wait_run();
        rd_chk(`RSC_ADDR_POWER_CONTROL, 8'h10);
        rd_chk(`RSC_ADDR_RSR, 8'h00);
        rd_chk(`RSC_ADDR_PMC, 8'h90);
        rd_chk(32'h00000004, 8'h00);
        xfer(`RSC_ADDR_POWER_CONTROL, 1'b1, 8'h00);
        rd_chk(`RSC_ADDR_POWER_CONTROL, 8'h00);
        // Watchdog, software and pin resets over random settings
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            v = (seed[7:0] & 8'h97) | (k > 0 ? 8'h08 : 8'h00);
            xfer(`RSC_ADDR_WATCHDOG_CONTROL, 1'b1, v);
            rd_chk(`RSC_ADDR_WATCHDOG_CONTROL, v);
            xfer(`RSC_ADDR_POWER_CONTROL, 1'b1, seed[15:8] & 8'h8f);
            #1 chk(CLK_STOP, seed[9]);
            case (k)
                0: src.wdt_fire();
                1: xfer(`RSC_ADDR_CHIP_CONTROL, 1'b1, 8'h80);
                default: src.pin_pulse(26 + seed[3:0]);
            endcase
            wait_rst();
            rd_chk(`RSC_ADDR_WATCHDOG_CONTROL, 8'h08);
            rd_chk(`RSC_ADDR_RSR, rsr_exp(k));
            rd_chk(`RSC_ADDR_POWER_CONTROL, 8'h00);
        end
        xfer(`RSC_ADDR_WATCHDOG_CONTROL, 1'b1, 8'h40);
        #1 chk(WDT_CLEAR, 1'b1);
        xfer(`RSC_ADDR_RSR, 1'b1, 8'h00);
        rd_chk(`RSC_ADDR_RSR, 8'h00);
        // Brown-out with reset enable clear, then set
        xfer(`RSC_ADDR_PMC, 1'b1, 8'h80);
        src.bod(1'b1);
        repeat (40) @(posedge CLK);
        chk(CPU_RESET, 1'b0);
        rd_chk(`RSC_ADDR_PMC, 8'h81);
        xfer(`RSC_ADDR_PMC, 1'b1, 8'h90);
        repeat (8) @(posedge CLK);
        chk(CPU_RESET, 1'b1);
        src.bod(1'b0);
        wait_run();
        rd_chk(`RSC_ADDR_RSR, 8'h04);
        chk(BOD_ENABLE, 1'b1);
        rd_chk(`RSC_ADDR_WATCHDOG_CONTROL, 8'h00);
        // Power-on after a watchdog reset
        src.wdt_fire();
        wait_rst();
        @(posedge CLK) NRST <= 1'b0;
        repeat (2) @(posedge CLK);
        NRST <= 1'b1;
        wait_run();
        rd_chk(`RSC_ADDR_POWER_CONTROL, 8'h10);
        rd_chk(`RSC_ADDR_RSR, 8'h00);
        rd_chk(`RSC_ADDR_WATCHDOG_CONTROL, 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
